//--- logic/loop_filter_lock_realign_ctrl.sv
// Oscillator control: filter select, slope limiting, lock indication and realignment
`timescale 1ns/1ns
module loop_filter_lock_realign_ctrl
  import timing_ctrl_pkg::*;
#(
  parameter logic [31:0] SEC_WIN      = 32'(SEC_CYC),
  parameter logic [31:0] LOW_0P1_WAIT = 32'(LOW_0P1_CYC),
  parameter logic [31:0] LOW_1P5_WAIT = 32'(LOW_1P5_CYC),
  parameter logic [31:0] RA_DROP_WAIT = 32'(RA_DROP_CYC),
  parameter logic [31:0] RA_LOW_WAIT  = 32'(RA_LOW_CYC),
  parameter logic [12:0] FRAME_LEN    = 13'(FRAME_CYC)
) (
  // Clock, reset, enable
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               ce,
  // Filter selection
  input  wire logic               filter_corner_select_pin,
  input  wire logic               filter_corner_select_bit,
  input  wire logic               filter_sel_from_pin,
  input  wire logic               filter_corner_select_hi,
  // Mode and realignment
  input  wire logic               mode_sel_hi,
  input  wire logic               mode_sel_lo,
  input  wire logic               phase_realign_n,
  // Phase detector
  input  wire logic signed [15:0] phase_err_ns,
  input  wire logic               phase_err_valid,
  input  wire logic               ref_is_8k,
  // Clock configuration pins
  input  wire logic               high_rate_cfg_pin,
  input  wire logic               tributary_cfg_pin,
  // Status
  output logic                    lock,
  output logic                    holdover,
  output logic [1:0]              filter_sel,
  output logic [31:0]             nco_phase,
  // Synthesized outputs
  output logic [NUM_CLK-1:0]      synth_clk,
  output logic                    frame_pulse_244_n,
  output logic                    frame_pulse_122,
  output logic                    frame_pulse_61_n
);
  typedef enum logic [0:0] {L_ACQ, L_LOCK} lock_st_t;
  typedef enum logic [1:0] {RA_IDLE, RA_HOLD, RA_WAIT, RA_REL} ra_st_t;

  typedef struct packed {
    logic [3:0]         s1;
    logic [3:0]         s2;
    logic               ra_prev;
    lock_st_t           lst;
    ra_st_t             ra;
    logic               ra_drop;
    logic [31:0]        low_cnt;
    logic [31:0]        ra_cnt;
    logic [3:0]         hold_cnt;
    logic [4:0]         settle;
    logic               lock;
    logic               holdover;
    logic [1:0]         fsel;
    logic [31:0]        phase;
    logic signed [15:0] trim;
    logic               align;
  } ctrl_state_t;

  localparam logic [3:0] HOLD_LAST = 4'(HOLD_CYC - 1);

  ctrl_state_t st_r;
  ctrl_state_t st_nxt;
  logic        normal;
  logic [15:0] err_mag;
  logic        err_small;
  logic        ra_start;
  logic        drop_fire;
  logic [31:0] min_low;
  logic [3:0]  shift;

  nco_if   nco_bus ();
  slope_if slp_bus ();

  // Loop correction passes through the slope limiter before touching the trim
  slope_limiter #(
    .SEC_WIN (SEC_WIN)
  ) u_slope (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .s     (slp_bus.lim)
  );

  clock_synth #(
    .FRAME_LEN (FRAME_LEN)
  ) u_synth (
    .clock         (clock),
    .rst           (rst),
    .ce            (ce),
    .n             (nco_bus.sink),
    .high_rate_cfg (st_r.s2[2]),
    .tributary_cfg (st_r.s2[3]),
    .clk_out       (synth_clk),
    .fp244_n       (frame_pulse_244_n),
    .fp122         (frame_pulse_122),
    .fp61_n        (frame_pulse_61_n)
  );

  assign normal    = !mode_sel_hi && !mode_sel_lo;
  assign err_mag   = phase_err_ns[15] ? 16'(-phase_err_ns) : 16'(phase_err_ns);
  assign err_small = err_mag <= LOCK_WIN_NS;
  assign ra_start  = normal && st_r.ra == RA_IDLE && st_r.ra_prev && !st_r.s2[1];
  assign drop_fire = st_r.ra == RA_WAIT && st_r.ra_cnt >= RA_DROP_WAIT - 32'h1;

  always_comb begin
    unique case (st_r.fsel)
      FILT_1P5: shift = SHIFT_1P5;
      FILT_0P1: shift = SHIFT_0P1;
      FILT_12:  shift = SHIFT_12;
      FILT_6:   shift = SHIFT_6;
    endcase
    if (st_r.fsel == FILT_0P1) min_low = LOW_0P1_WAIT;
    else if (st_r.fsel == FILT_1P5) min_low = LOW_1P5_WAIT;
    else min_low = 32'h0;
  end

  // Holdover freezes frequency, so no correction is requested while it lasts
  assign slp_bus.fsel      = st_r.fsel;
  assign slp_bus.req       = phase_err_ns >>> shift;
  assign slp_bus.req_valid = phase_err_valid && normal && !st_r.holdover;

  assign nco_bus.phase = st_r.phase;
  assign nco_bus.trim  = st_r.trim;
  assign nco_bus.align = st_r.align;
  assign nco_bus.valid = 1'b1;

  always_comb begin
    st_nxt = st_r;
    // Pins enter through two flops; only s2 and later stages feed logic
    st_nxt.s1 = {tributary_cfg_pin, high_rate_cfg_pin, phase_realign_n,
                 filter_corner_select_pin};
    st_nxt.s2      = st_r.s1;
    st_nxt.ra_prev = st_r.s2[1];
    st_nxt.align   = 1'b0;
    st_nxt.fsel = {filter_corner_select_hi,
                   filter_sel_from_pin ? st_r.s2[0] : filter_corner_select_bit};

    // Free-running phase word stream
    st_nxt.phase = st_r.phase + NCO_NOM + 32'(st_r.trim);
    // Trim wraps on overflow; the limiter keeps steps small enough in practice
    if (slp_bus.grant_valid && !st_r.holdover) begin
      st_nxt.trim = st_r.trim + slp_bus.grant;
    end

    if (st_r.low_cnt != 32'h0) begin
      st_nxt.low_cnt = st_r.low_cnt - 32'h1;
    end
    if (st_r.ra == RA_HOLD || st_r.ra == RA_WAIT) begin
      st_nxt.ra_cnt = st_r.ra_cnt + 32'h1;
    end

    unique case (st_r.ra)
      RA_IDLE: begin
        if (ra_start) begin
          st_nxt.ra       = RA_HOLD;
          st_nxt.ra_cnt   = 32'h0;
          st_nxt.hold_cnt = HOLD_LAST;
          st_nxt.holdover = 1'b1;
          st_nxt.align    = 1'b1;
          st_nxt.ra_drop  = !ref_is_8k && !st_r.fsel[1] && st_r.lock;
        end
      end
      RA_HOLD: begin
        if (st_r.hold_cnt == 4'h0) begin
          st_nxt.holdover = 1'b0;
          st_nxt.ra       = st_r.ra_drop ? RA_WAIT : RA_REL;
        end else begin
          st_nxt.hold_cnt = st_r.hold_cnt - 4'h1;
        end
      end
      RA_WAIT: begin
        if (drop_fire) begin
          st_nxt.ra = RA_REL;
        end
      end
      RA_REL: begin
        // A new realignment needs the pin released and pulled low again
        if (st_r.s2[1]) begin
          st_nxt.ra = RA_IDLE;
        end
      end
    endcase

    unique case (st_r.lst)
      L_ACQ: begin
        if (!normal || (phase_err_valid && !err_small)) begin
          st_nxt.settle = 5'h0;
        end else if (phase_err_valid && st_r.settle != SETTLE_LAST) begin
          st_nxt.settle = st_r.settle + 5'h1;
        end
        if (drop_fire) begin
          st_nxt.low_cnt = RA_LOW_WAIT;
        end else if (normal && phase_err_valid && err_small &&
                     st_r.settle == SETTLE_LAST && st_r.low_cnt == 32'h0) begin
          st_nxt.lst  = L_LOCK;
          st_nxt.lock = 1'b1;
        end
      end
      L_LOCK: begin
        // Error excursions are ignored while a realignment is in progress
        if (!normal || drop_fire ||
            (phase_err_valid && !err_small && st_r.ra == RA_IDLE)) begin
          st_nxt.lst     = L_ACQ;
          st_nxt.lock    = 1'b0;
          st_nxt.settle  = 5'h0;
          st_nxt.low_cnt = drop_fire ? RA_LOW_WAIT : min_low;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) st_r <= '{s1: 4'hF, s2: 4'hF, ra_prev: 1'b1, lst: L_ACQ, ra: RA_IDLE,
                        default: '0};
    else if (ce) st_r <= st_nxt;
  end

  assign lock       = st_r.lock;
  assign holdover   = st_r.holdover;
  assign filter_sel = st_r.fsel;
  assign nco_phase  = st_r.phase;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || !ce);

  filt_map_a: assert property (
    !filter_sel_from_pin |=> filter_sel == $past({filter_corner_select_hi,
                                                  filter_corner_select_bit}))
    else $error("filter select does not follow the select bits");
  lock_entry_a: assert property (
    $rose(lock) |-> $past(phase_err_valid && err_small && normal && st_r.low_cnt == 32'h0))
    else $error("lock rose without a small residual error");
  low_load_a: assert property (
    $fell(lock) && $past(st_r.fsel == FILT_0P1 && normal && !drop_fire)
      |-> st_r.low_cnt == LOW_0P1_WAIT)
    else $error("lock low time not loaded for 0.1 Hz filter");
  hold_len_a: assert property (
    $rose(holdover) |-> ##9 holdover ##1 !holdover)
    else $error("holdover pulse length wrong");
  trim_frozen_a: assert property (
    holdover |=> st_r.trim == $past(st_r.trim))
    else $error("trim moved during holdover");
  drop_time_a: assert property (
    $fell(lock) && $past(st_r.ra == RA_WAIT && normal)
      |-> $past(st_r.ra_cnt) >= RA_DROP_WAIT - 32'h1 && st_r.low_cnt == RA_LOW_WAIT)
    else $error("realign lock drop at wrong time");
  keep_high_a: assert property (
    st_r.ra != RA_IDLE && !st_r.ra_drop && lock && normal |=> lock)
    else $error("lock fell during a keep-high realignment");
  mode_norm_a: assert property (
    !normal |=> !lock)
    else $error("lock high outside normal mode");
  nco_run_a: assert property (
    1'b1 |=> nco_phase != $past(nco_phase))
    else $error("phase word stream stalled");

  lock_gain_c: cover property ($rose(lock));
  drop_fire_c: cover property (drop_fire && lock);
  keep_high_c: cover property (st_r.ra == RA_REL && !st_r.ra_drop && lock);
  holdover_c:  cover property ($fell(holdover));

endmodule : loop_filter_lock_realign_ctrl

//--- shared/timing_ctrl_pkg.sv
// Constants and helpers shared by the loop filter, lock and clock synthesis logic
package timing_ctrl_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_NS = 20;

  // Filter select codes, {hi, lo}
  localparam logic [1:0] FILT_1P5 = 2'h0;
  localparam logic [1:0] FILT_0P1 = 2'h1;
  localparam logic [1:0] FILT_12  = 2'h2;
  localparam logic [1:0] FILT_6   = 2'h3;

  // Loop gain as a right shift of the phase error
  localparam logic [3:0] SHIFT_1P5 = 4'h3;
  localparam logic [3:0] SHIFT_0P1 = 4'h6;
  localparam logic [3:0] SHIFT_12  = 4'h0;
  localparam logic [3:0] SHIFT_6   = 4'h1;

  // Phase slope budgets in ns per window
  localparam int unsigned SLOPE_WIN_NS  = 1_326_000;
  localparam int unsigned SLOPE_WIN_CYC = SLOPE_WIN_NS / CLK_NS;
  localparam int unsigned SEC_CYC       = CLK_HZ;
  localparam logic [20:0] BUDGET_1P5_NS = 21'h00029;
  localparam logic [20:0] BUDGET_0P1_NS = 21'h00375;
  localparam logic [20:0] BUDGET_12_NS  = 21'h124F80;
  localparam logic [20:0] BUDGET_6_NS   = 21'h00032;

  // Lock and realign timing
  localparam logic [15:0] LOCK_WIN_NS  = 16'h0014;
  localparam logic [4:0]  SETTLE_LAST  = 5'h0F;
  localparam longint unsigned LOW_0P1_S = 65;
  localparam longint unsigned LOW_1P5_S = 10;
  localparam longint unsigned RA_DROP_S = 5;
  localparam longint unsigned RA_LOW_S  = 10;
  localparam longint unsigned LOW_0P1_CYC = LOW_0P1_S * CLK_HZ;
  localparam longint unsigned LOW_1P5_CYC = LOW_1P5_S * CLK_HZ;
  localparam longint unsigned RA_DROP_CYC = RA_DROP_S * CLK_HZ;
  localparam longint unsigned RA_LOW_CYC  = RA_LOW_S * CLK_HZ;
  localparam int unsigned HOLD_NS  = 200;
  localparam int unsigned HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;

  // Frame pulses, least widths rounded up
  localparam int unsigned FRAME_HZ  = 8000;
  localparam int unsigned FRAME_CYC = CLK_HZ / FRAME_HZ;
  localparam int unsigned FP244_NS  = 244;
  localparam int unsigned FP122_NS  = 122;
  localparam int unsigned FP61_NS   = 61;
  localparam logic [12:0] FP244_CYC = 13'((FP244_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [12:0] FP122_CYC = 13'((FP122_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [12:0] FP61_CYC  = 13'((FP61_NS + CLK_NS - 1) / CLK_NS);

  function automatic logic [31:0] tune_word(input longint unsigned khz);
    tune_word = 32'(((khz * 1000) << 32) / CLK_HZ);
  endfunction : tune_word

  localparam int unsigned NUM_CLK     = 12;
  localparam int unsigned IDX_8M592   = 5;
  localparam int unsigned IDX_11M184  = 6;
  localparam int unsigned IDX_34M368  = 9;
  localparam int unsigned IDX_44M736  = 10;
  localparam int unsigned IDX_155M    = 11;
  localparam logic [31:0] NCO_NOM     = tune_word(16384);
  localparam logic [NUM_CLK-1:0][31:0] TUNE = {
    tune_word(155520), tune_word(44736), tune_word(34368), tune_word(19440),
    tune_word(16384), tune_word(11184), tune_word(8592), tune_word(8192),
    tune_word(6132), tune_word(4096), tune_word(2048), tune_word(1544)};

endpackage : timing_ctrl_pkg

//--- shared/timing_ifs.sv
// Interfaces between the control core, the slope limiter and the synthesizer
`timescale 1ns/1ns
interface nco_if;
  logic [31:0]        phase;
  logic signed [15:0] trim;
  logic               align;
  logic               valid;
  modport src  (output phase, trim, align, valid);
  modport sink (input phase, trim, align, valid);
endinterface : nco_if

interface slope_if;
  logic [1:0]         fsel;
  logic signed [15:0] req;
  logic               req_valid;
  logic signed [15:0] grant;
  logic               grant_valid;
  modport user (output fsel, req, req_valid, input grant, grant_valid);
  modport lim  (input fsel, req, req_valid, output grant, grant_valid);
endinterface : slope_if

//--- logic/slope_limiter.sv
// Phase slope limiter for the loop filter trim
`timescale 1ns/1ns
module slope_limiter
  import timing_ctrl_pkg::*;
#(
  parameter logic [31:0] SEC_WIN = 32'(SEC_CYC)
) (
  // Clock and control
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Request and grant
  slope_if.lim     s
);
  typedef struct packed {
    logic [31:0]        win;
    logic [20:0]        used;
    logic signed [15:0] grant;
    logic               gv;
  } lim_state_t;

  lim_state_t  st_r;
  lim_state_t  st_nxt;
  logic [31:0] win_len;
  logic [20:0] half;
  logic [20:0] base;
  logic [20:0] room;
  logic [15:0] mag;
  logic [15:0] gmag;

  assign s.grant       = st_r.grant;
  assign s.grant_valid = st_r.gv;
  assign gmag = st_r.grant[15] ? 16'(-st_r.grant) : 16'(st_r.grant);

  always_comb begin
    unique case (s.fsel)
      FILT_1P5: begin win_len = 32'(SLOPE_WIN_CYC); half = BUDGET_1P5_NS >> 1; end
      FILT_0P1: begin win_len = SEC_WIN; half = BUDGET_0P1_NS >> 1; end
      FILT_12:  begin win_len = SEC_WIN; half = BUDGET_12_NS >> 1; end
      FILT_6:   begin win_len = 32'(SLOPE_WIN_CYC); half = BUDGET_6_NS >> 1; end
    endcase
    st_nxt    = st_r;
    st_nxt.gv = 1'b0;
    // Half budget per fixed window: any sliding window spans two at most
    if (st_r.win >= win_len - 32'h1) begin
      st_nxt.win = 32'h0;
      base       = 21'h0;
    end else begin
      st_nxt.win = st_r.win + 32'h1;
      base       = st_r.used;
    end
    room = (base >= half) ? 21'h0 : half - base;
    mag  = s.req[15] ? 16'(-s.req) : 16'(s.req);
    st_nxt.used = base;
    if (s.req_valid) begin
      st_nxt.gv = 1'b1;
      if (21'(mag) <= room) begin
        st_nxt.grant = s.req;
        st_nxt.used  = base + 21'(mag);
      end else begin
        st_nxt.grant = s.req[15] ? -16'(room) : 16'(room);
        st_nxt.used  = base + room;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) st_r <= '0;
    else if (ce) st_r <= st_nxt;
  end

  slope_cap_a: assert property (@(posedge clock) disable iff (rst || !ce)
    st_r.gv |-> 21'(gmag) <= $past(half)) else $error("slope grant exceeds budget");

endmodule : slope_limiter

//--- logic/clock_synth.sv
// Output clock and frame pulse synthesizer fed by the oscillator trim and align
`timescale 1ns/1ns
module clock_synth
  import timing_ctrl_pkg::*;
#(
  parameter logic [12:0] FRAME_LEN = 13'(FRAME_CYC)
) (
  // Clock and control
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               ce,
  // Phase stream and configuration
  nco_if.sink                     n,
  input  wire logic               high_rate_cfg,
  input  wire logic               tributary_cfg,
  // Outputs
  output logic [NUM_CLK-1:0]      clk_out,
  output logic                    fp244_n,
  output logic                    fp122,
  output logic                    fp61_n
);
  typedef struct packed {
    logic [NUM_CLK-1:0][31:0] acc;
    logic [12:0]              fcnt;
    logic [NUM_CLK-1:0]       clk;
    logic                     fp244_n;
    logic                     fp122;
    logic                     fp61_n;
  } syn_state_t;

  syn_state_t               st_r;
  syn_state_t               st_nxt;
  logic [NUM_CLK-1:0][31:0] acc_step;
  logic [NUM_CLK-1:0]       en;

  // Each channel is a phase accumulator tracking the oscillator trim
  for (genvar k = 0; k < NUM_CLK; k++) begin : g_ch
    assign acc_step[k] = st_r.acc[k] + TUNE[k] + 32'(n.trim);
  end

  // Accumulator MSB gives 50% nominal; the two tributary rates tolerate wider skew
  always_comb begin
    en             = '1;
    en[IDX_155M]   = high_rate_cfg;
    en[IDX_34M368] = tributary_cfg;
    en[IDX_44M736] = !tributary_cfg;
    st_nxt = st_r;
    if (n.align) begin
      st_nxt.acc  = '0;
      st_nxt.fcnt = 13'h0;
    end else if (n.valid) begin
      st_nxt.acc  = acc_step;
      st_nxt.fcnt = (st_r.fcnt == FRAME_LEN - 13'h1) ? 13'h0 : st_r.fcnt + 13'h1;
    end
    for (int i = 0; i < NUM_CLK; i++) begin
      st_nxt.clk[i] = en[i] & st_nxt.acc[i][31];
    end
    st_nxt.fp244_n = !(st_nxt.fcnt < FP244_CYC);
    st_nxt.fp122   = st_nxt.fcnt < FP122_CYC;
    st_nxt.fp61_n  = !(st_nxt.fcnt < FP61_CYC);
  end

  always_ff @(posedge clock) begin
    // Counter parks on the last count so the first frame after reset is full width
    if (rst) st_r <= '{fcnt: FRAME_LEN - 13'h1, fp244_n: 1'b1, fp61_n: 1'b1, default: '0};
    else if (ce) st_r <= st_nxt;
  end

  assign clk_out = st_r.clk;
  assign fp244_n = st_r.fp244_n;
  assign fp122   = st_r.fp122;
  assign fp61_n  = st_r.fp61_n;

  fp244_width_a: assert property (@(posedge clock) disable iff (rst || !ce || n.align)
    $fell(fp244_n) |-> ##12 !fp244_n ##1 fp244_n) else $error("244 ns pulse width wrong");
  fp61_width_a: assert property (@(posedge clock) disable iff (rst || !ce || n.align)
    $fell(fp61_n) |-> ##3 !fp61_n ##1 fp61_n) else $error("61 ns pulse width wrong");
  frame_seen_c: cover property (@(posedge clock) disable iff (rst) $rose(fp122));

endmodule : clock_synth

//--- testbench/realign_host.sv
// Control processor model that runs the realign procedure on request
`timescale 1ns/1ns
module realign_host (
  // Clock and request
  input  wire logic        clock,
  input  wire logic        go,
  input  wire logic [31:0] hold_cyc,
  // Device status and control
  input  wire logic        lock,
  output logic             phase_realign_n,
  output logic             done
);
  // Pin held low by cycle count, never shorter than asked
  initial begin
    phase_realign_n = 1'b1;
    done            = 1'b0;
    forever begin
      @(posedge clock);
      if (go && !done) begin
        while (lock !== 1'b1) @(posedge clock);
        phase_realign_n <= 1'b0;
        repeat (hold_cyc) @(posedge clock);
        phase_realign_n <= 1'b1;
        done <= 1'b1;
      end else if (!go) begin
        done <= 1'b0;
      end
    end
  end
endmodule : realign_host

//--- testbench/loop_filter_lock_realign_ctrl_tb_top.sv
// Self-checking bench for the oscillator control block
`timescale 1ns/1ns
module loop_filter_lock_realign_ctrl_tb_top;
  import timing_ctrl_pkg::*;
  localparam int LOW0 = 650, LOW1 = 100, DROP = 50, FLEN = 200;
  // Realign hold of 250 us, and a shortened 8 kHz hold
  localparam logic [31:0] RA250 = 32'h30D4, RA8K = 32'h1F4;
  logic clock = 0, rst = 1, ce = 1, fpin = 1, fbit = 0, fsrc = 0, fhi = 0;
  logic ref8k = 0, hcfg = 0, tcfg = 0, big = 0, go = 0, valid = 0, msh = 0, msl = 0;
  logic signed [15:0] err = 0;
  logic lock, hold, ra_n, done, fp244_n, fp122, fp61_n;
  logic [1:0] fsel;
  logic [31:0] ph, hold_cyc = RA250;
  logic [NUM_CLK-1:0] sclk, prev, tog;
  int num_errors = 0, comparisons = 0, n, k, hw, low_at, a, b, d, hi0, pc;
  logic [1:0] cf [4] = '{2'h0, 2'h3, 2'h2, 2'h0};
  logic c8k [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  always #10 clock = ~clock;
  loop_filter_lock_realign_ctrl #(.SEC_WIN(32'h3E8), .LOW_0P1_WAIT(32'(LOW0)),
    .LOW_1P5_WAIT(32'(LOW1)), .RA_DROP_WAIT(32'(DROP)), .RA_LOW_WAIT(32'h64),
    .FRAME_LEN(13'(FLEN))) u_loop_filter_lock_realign_ctrl (
    .clock(clock), .rst(rst), .ce(ce), .filter_corner_select_pin(fpin),
    .filter_corner_select_bit(fbit), .filter_sel_from_pin(fsrc),
    .filter_corner_select_hi(fhi), .mode_sel_hi(msh), .mode_sel_lo(msl),
    .phase_realign_n(ra_n), .phase_err_ns(err), .phase_err_valid(valid),
    .ref_is_8k(ref8k), .high_rate_cfg_pin(hcfg), .tributary_cfg_pin(tcfg),
    .lock(lock), .holdover(hold), .filter_sel(fsel), .nco_phase(ph), .synth_clk(sclk),
    .frame_pulse_244_n(fp244_n), .frame_pulse_122(fp122), .frame_pulse_61_n(fp61_n));
  realign_host u_realign_host (.clock(clock), .go(go), .hold_cyc(hold_cyc), .lock(lock),
    .phase_realign_n(ra_n), .done(done));
  // Small errors settle the loop; big ones break lock
  always @(posedge clock) begin
    valid <= $urandom_range(3) != 0;
    err <= big ? 16'sh19 : 16'($urandom_range(40)) - 16'sh14;
  end
  // Sampling at the edge sees the values settled before it
  task automatic tick();
    @(posedge clock);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_lock();
    for (int i = 0; i < 2000 && lock !== 1'b1; i++) tick();
    chk(32'(lock), 1);
  endtask : wait_lock
  task automatic set_filter(input logic [1:0] code);
    fsrc <= 1'($urandom);
    fpin <= code[0];
    fbit <= code[0];
    fhi <= code[1];
    repeat (5) tick();
    chk(32'(fsel), 32'(code));
  endtask : set_filter
  task automatic conclude();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  initial begin
    repeat (100000) tick();
    num_errors++;
    conclude();
  end
  initial begin
    void'($urandom(32'h933D));
    repeat (4) tick();
    chk({29'h0, lock, hold, fsel != 2'h0}, 0);
    chk({sclk, 17'h0, fp244_n, fp122, fp61_n}, 32'h5);
    chk(ph, 0);
    rst <= 1'b0;
    hcfg <= 1'($urandom);
    tcfg <= 1'($urandom);
    for (int c = 0; c < 4; c++) set_filter(2'(c));
    repeat (10) tick();
    {a, b, d, hi0, pc, tog} = '0;
    prev = sclk;
    for (int i = 0; i < FLEN; i++) begin
      k = ph;
      tick();
      a += !fp244_n;
      b += fp122;
      d += !fp61_n;
      hi0 += sclk[0];
      pc += (ph != k);
      tog |= sclk ^ prev;
      prev = sclk;
    end
    chk(a, (FP244_NS + CLK_NS - 1) / CLK_NS);
    chk(b, (FP122_NS + CLK_NS - 1) / CLK_NS);
    chk(d, (FP61_NS + CLK_NS - 1) / CLK_NS);
    chk(32'(hi0 > 80 && hi0 < 120), 1);
    chk(pc, FLEN);
    chk(32'(tog), {20'h0, hcfg, !tcfg, tcfg, 9'h1FF});
    // Minimum low time after a lock loss, and no lock on big errors
    for (int c = 0; c < 3; c++) begin
      set_filter(c == 0 ? 2'h1 : c == 1 ? 2'h0 : 2'h3);
      wait_lock();
      big <= 1'b1;
      for (int i = 0; i < 10 && lock !== 1'b0; i++) tick();
      big <= (c == 2);
      n = 0;
      repeat (c == 0 ? LOW0 : c == 1 ? LOW1 : 40) begin
        tick();
        n += (lock !== 1'b0);
      end
      chk(n, 0);
      big <= 1'b0;
      wait_lock();
    end
    // Leaving normal mode drops lock and keeps it low despite small errors
    {msh, msl} <= 2'($urandom_range(3, 1));
    repeat (2) tick();
    n = 0;
    repeat (30) begin
      tick();
      n += (lock !== 1'b0);
    end
    chk(n, 0);
    {msh, msl} <= 2'h0;
    wait_lock();
    // Realign: holdover width, lock drop only for slow filters on fast references
    for (int c = 0; c < 4; c++) begin
      set_filter(cf[c]);
      ref8k <= c8k[c];
      hold_cyc <= c8k[c] ? RA8K : RA250;
      wait_lock();
      go <= 1'b1;
      for (int i = 0; i < 100 && hold !== 1'b1; i++) tick();
      hw = 0;
      low_at = -1;
      for (int i = 0; i < 300; i++) begin
        hw += (hold === 1'b1);
        if (lock !== 1'b1 && low_at < 0) low_at = i;
        tick();
      end
      chk(hw, HOLD_CYC);
      chk(low_at, (c == 0) ? DROP : -1);
      for (int i = 0; i < 20000 && done !== 1'b1; i++) tick();
      go <= 1'b0;
      tick();
      wait_lock();
    end
    conclude();
  end
endmodule : loop_filter_lock_realign_ctrl_tb_top
